// File: design/bgf_delay_timer.sv
// qualifying delay timer: done once cond has held for limit ticks
`timescale 1ns/10ps
module bgf_delay_timer import bgf_pkg::*; (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  done
);
    logic [CNT_W-1:0] count;

    // a dropout before expiry throws the partial count away
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (tick && count < limit) begin
            count <= count + CNT_W'(1);
        end
    end

    assign done = cond && (count >= limit);
endmodule

// File: design/bgf_guard.sv
// protection state logic for a two-cell pack: gates, pulls and standby
//
// Functional notes
// - overcharge on either cell drops charge gate after counted delay.
// - overcharge state blocks over-current detection, short still detected.
// - load after overcharge selects the small comparator hysteresis.
// - overcharge releases when both cells are low and load node allows.
// - load present, node high, a cell still high: charge gate stays low.
// - excess charger at release starts excess detection, gate stays low.
// - over-discharge on either cell drops discharge gate after delay.
// - over-discharge detection enters standby, monitoring stops.
// - over-discharge detection enables the pull-up to supply.
// - standby ends only when charger pulls load node to release level.
// - after wake, both cells recovered raise discharge gate after delay.
// - over-current on load node drops discharge gate after delay.
// - over-current or short enables the pull-down to ground.
// - over-current detection never enters standby.
// - excess charger detection is qualified by a 1.5 ms delay.
// - excess charger release is qualified by a 1.5 ms delay.
// - excess charger count is held off during over-discharge.
// - test pin high shortens delays; low or open gives normal delays.
// - shortening acts on counter delays only, never the short delay.
// - short level trips discharge gate faster, without standby.
// - load node back below threshold releases after counted delay.
// - excess charger drops charge gate; clearing early abandons it.
`timescale 1ns/10ps
module bgf_guard import bgf_pkg::*; #(
    parameter int DET_OVCHG_TICKS  = TD_OVCHG_TICKS,
    parameter int REL_OVCHG_TICKS  = TR_OVCHG_TICKS,
    parameter int DET_OVDIS_TICKS  = TD_OVDIS_TICKS,
    parameter int REL_OVDIS_TICKS  = TR_OVDIS_TICKS,
    parameter int DET_OCUR_TICKS   = TD_OCUR_TICKS,
    parameter int REL_OCUR_TICKS   = TR_OCUR_TICKS,
    parameter int DET_EXCESS_TICKS = TD_EXCESS_TICKS,
    parameter int REL_EXCESS_TICKS = TR_EXCESS_TICKS
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire bgf_comp_type  comp,
    input  wire logic          test_shorten,
    output bgf_drive_type      drive
);
    typedef enum logic [1:0] {
        CHG_NORMAL,
        CHG_OVER,
        CHG_PEND,
        CHG_EXCESS
    } bgf_chg_type;

    typedef enum logic [2:0] {
        DIS_NORMAL,
        DIS_STBY,
        DIS_WAKE,
        DIS_OVERCUR,
        DIS_SHORT
    } bgf_dis_type;

    bgf_chg_type   chg_state;
    bgf_chg_type   next_chg;
    bgf_dis_type   dis_state;
    bgf_dis_type   next_dis;
    bgf_drive_type next_drive;

    logic tick;
    logic ocd_done;
    logic ocr_done;
    logic exd_done;
    logic exr_done;
    logic odd_done;
    logic odr_done;
    logic ocu_done;
    logic sc_done;
    logic ocrl_done;

    // detection and release conditions
    wire dis_on     = (dis_state == DIS_NORMAL);
    wire dis_trip   = (dis_state == DIS_OVERCUR) ||
                      (dis_state == DIS_SHORT);
    wire both_rel   = &comp.ovchg_rel;
    wire node_ok    = !comp.load_ocur || comp.load_present;
    wire ocd_cond   = (chg_state == CHG_NORMAL) && |comp.ovchg_det;
    wire ocr_cond   = (chg_state == CHG_OVER) && both_rel && node_ok;
    // charger detection only while discharge gate is on
    wire exd_cond   = comp.excess_chg && dis_on &&
                      ((chg_state == CHG_NORMAL) ||
                       (chg_state == CHG_PEND));
    wire exr_cond   = (chg_state == CHG_EXCESS) && !comp.excess_chg;
    wire odd_cond   = (dis_on || dis_trip) && |comp.ovdis_det;
    wire odr_cond   = (dis_state == DIS_WAKE) && &comp.ovdis_rel;
    wire ocu_cond   = dis_on && comp.load_ocur &&
                      (chg_state != CHG_OVER);
    wire sc_cond    = dis_on && comp.load_short;
    wire ocrl_cond  = dis_trip && !comp.load_ocur;

    // counted limits; test pin only scales counter-derived delays
    // a floating test pin is taken as low by the pad
    wire [CNT_W-1:0] lim_ocd  =
        scale_delay(CNT_W'(DET_OVCHG_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_ocr  =
        scale_delay(CNT_W'(REL_OVCHG_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_exd  =
        scale_delay(CNT_W'(DET_EXCESS_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_exr  =
        scale_delay(CNT_W'(REL_EXCESS_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_odd  =
        scale_delay(CNT_W'(DET_OVDIS_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_odr  =
        scale_delay(CNT_W'(REL_OVDIS_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_ocu  =
        scale_delay(CNT_W'(DET_OCUR_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_ocrl =
        scale_delay(CNT_W'(REL_OCUR_TICKS), test_shorten);
    wire [CNT_W-1:0] lim_sc   = CNT_W'(TD_SHORT_TICKS);

    // oscillator halts in standby, so no count can advance
    bgf_tick_div u_tick (
        .clk  (clk),
        .rst  (rst),
        .run  (!drive.standby),
        .tick (tick)
    );

    bgf_delay_timer u_ocd (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (ocd_cond),
        .limit (lim_ocd),
        .done  (ocd_done)
    );

    bgf_delay_timer u_ocr (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (ocr_cond),
        .limit (lim_ocr),
        .done  (ocr_done)
    );

    bgf_delay_timer u_exd (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (exd_cond),
        .limit (lim_exd),
        .done  (exd_done)
    );

    bgf_delay_timer u_exr (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (exr_cond),
        .limit (lim_exr),
        .done  (exr_done)
    );

    bgf_delay_timer u_odd (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (odd_cond),
        .limit (lim_odd),
        .done  (odd_done)
    );

    bgf_delay_timer u_odr (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (odr_cond),
        .limit (lim_odr),
        .done  (odr_done)
    );

    bgf_delay_timer u_ocu (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (ocu_cond),
        .limit (lim_ocu),
        .done  (ocu_done)
    );

    bgf_delay_timer u_sc (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (sc_cond),
        .limit (lim_sc),
        .done  (sc_done)
    );

    bgf_delay_timer u_ocrl (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .cond  (ocrl_cond),
        .limit (lim_ocrl),
        .done  (ocrl_done)
    );

    // charge side: overcharge, pending charger check, excess charger
    always_comb begin
        next_chg = chg_state;
        case (chg_state)
            CHG_NORMAL: begin
                if (ocd_done) begin
                    next_chg = CHG_OVER;
                end else if (exd_done) begin
                    next_chg = CHG_EXCESS;
                end
            end
            CHG_OVER: begin
                if (ocr_done) begin
                    // charger still too high: keep gate off
                    next_chg = comp.excess_chg ? CHG_PEND : CHG_NORMAL;
                end
            end
            CHG_PEND: begin
                if (exd_done) begin
                    next_chg = CHG_EXCESS;
                end else if (!comp.excess_chg) begin
                    next_chg = CHG_NORMAL;
                end
            end
            CHG_EXCESS: begin
                if (exr_done) begin
                    next_chg = CHG_NORMAL;
                end
            end
            default: begin
                next_chg = CHG_NORMAL;
            end
        endcase
    end

    // discharge side: short beats over-current, over-discharge ranks last
    always_comb begin
        next_dis = dis_state;
        case (dis_state)
            DIS_NORMAL: begin
                if (sc_done) begin
                    next_dis = DIS_SHORT;
                end else if (ocu_done) begin
                    next_dis = DIS_OVERCUR;
                end else if (odd_done) begin
                    next_dis = DIS_STBY;
                end
            end
            DIS_STBY: begin
                if (comp.stby_release) begin
                    next_dis = DIS_WAKE;
                end
            end
            DIS_WAKE: begin
                if (odr_done) begin
                    next_dis = DIS_NORMAL;
                end
            end
            DIS_OVERCUR, DIS_SHORT: begin
                if (ocrl_done) begin
                    next_dis = DIS_NORMAL;
                end else if (odd_done) begin
                    next_dis = DIS_STBY;
                end
            end
            default: begin
                next_dis = DIS_NORMAL;
            end
        endcase
    end

    // pin controls decoded from the next states so they move with them
    assign next_drive.chg_gate    = (next_chg == CHG_NORMAL);
    assign next_drive.dis_gate    = (next_dis == DIS_NORMAL);
    assign next_drive.pullup_en   = (next_dis == DIS_STBY);
    assign next_drive.pulldown_en = (next_dis == DIS_OVERCUR) ||
                                    (next_dis == DIS_SHORT);
    assign next_drive.standby     = (next_dis == DIS_STBY);
    assign next_drive.small_hyst  = (next_chg == CHG_OVER) &&
                                    comp.load_present;

    // state and pin registers; reset leaves gates on, pulls off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chg_state <= CHG_NORMAL;
            dis_state <= DIS_NORMAL;
            drive     <= DRIVE_RESET;
        end else begin
            chg_state <= next_chg;
            dis_state <= next_dis;
            drive     <= next_drive;
        end
    end

    // checks on the pin behaviour
    ovchg_fall_a: assert property (@(posedge clk) disable iff (rst)
        $fell(drive.chg_gate) |-> $past(ocd_done || exd_done))
        else $error("charge gate fell without a qualified detection");

    ocur_block_a: assert property (@(posedge clk) disable iff (rst)
        $rose(drive.pulldown_en) && $past(chg_state == CHG_OVER)
        |-> $past(sc_done))
        else $error("over-current tripped during overcharge");

    hyst_sel_a: assert property (@(posedge clk) disable iff (rst)
        drive.small_hyst |-> !drive.chg_gate && chg_state == CHG_OVER)
        else $error("small hysteresis outside overcharge");

    ovchg_rise_a: assert property (@(posedge clk) disable iff (rst)
        $rose(drive.chg_gate) |-> $past(ocr_done || exr_done ||
        (chg_state == CHG_PEND && !comp.excess_chg)))
        else $error("charge gate rose without a release");

    keep_low_a: assert property (@(posedge clk) disable iff (rst)
        chg_state == CHG_OVER && comp.load_ocur && comp.load_present &&
        !both_rel |=> !drive.chg_gate)
        else $error("charge gate rose with a cell still high");

    excess_hold_a: assert property (@(posedge clk) disable iff (rst)
        chg_state == CHG_OVER && ocr_done && comp.excess_chg
        |=> chg_state == CHG_PEND && !drive.chg_gate)
        else $error("charge gate released into an excess charger");

    dis_fall_a: assert property (@(posedge clk) disable iff (rst)
        $fell(drive.dis_gate) |-> $past(odd_done || ocu_done || sc_done))
        else $error("discharge gate fell without a detection");

    stby_entry_a: assert property (@(posedge clk) disable iff (rst)
        $rose(drive.standby) |-> drive.pullup_en && !drive.dis_gate &&
        !drive.pulldown_en)
        else $error("standby entered without pull-up");

    stby_hold_a: assert property (@(posedge clk) disable iff (rst)
        drive.standby && !comp.stby_release |=> drive.standby)
        else $error("standby left without release level");

    trip_nostby_a: assert property (@(posedge clk) disable iff (rst)
        drive.pulldown_en |-> !drive.standby && !drive.dis_gate)
        else $error("over-current state with standby");

    dis_rise_a: assert property (@(posedge clk) disable iff (rst)
        $rose(drive.dis_gate) |-> $past(odr_done || ocrl_done))
        else $error("discharge gate rose without a release");

    // bounded windows sized for the shortened delays used in simulation
    ovchg_cycle_c: cover property (@(posedge clk) disable iff (rst)
        $fell(drive.chg_gate) ##[1:1000] $rose(drive.chg_gate));
    stby_cycle_c: cover property (@(posedge clk) disable iff (rst)
        $rose(drive.standby) ##[1:1000] $rose(drive.dis_gate));
    short_trip_c: cover property (@(posedge clk) disable iff (rst)
        sc_done ##1 drive.pulldown_en);
endmodule

// File: design/bgf_tick_div.sv
// divider that makes the delay-counter tick from the system clock
`timescale 1ns/10ps
module bgf_tick_div import bgf_pkg::*; (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    logic [TICK_W-1:0] div;

    // stopping the divider models the oscillator halted in standby
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div <= '0;
        end else if (!run || div == TICK_W'(TICK_CYCLES - 1)) begin
            div <= '0;
        end else begin
            div <= div + TICK_W'(1);
        end
    end

    assign tick = run && (div == TICK_W'(TICK_CYCLES - 1));
endmodule

// File: pkg/bgf_pkg.sv
// shared constants, delay figures and carrier types for the battery guard
package bgf_pkg;

    // clock and delay-counter time base
    localparam int CLK_NS      = 40;
    localparam int TICK_NS     = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int TICK_W      = 5;
    localparam int CNT_W       = 21;
    localparam int SHORT_SHIFT = 6;

    // nominal delays in microseconds
    localparam int TD_OVCHG_US  = 1000000;
    localparam int TR_OVCHG_US  = 40000;
    localparam int TD_OVDIS_US  = 100000;
    localparam int TR_OVDIS_US  = 1000;
    localparam int TD_OCUR_US   = 20000;
    localparam int TR_OCUR_US   = 1000;
    localparam int TD_SHORT_US  = 250;
    localparam int EXCESS_CHARGER_DETECT_DELAY_US  = 1500;
    localparam int EXCESS_CHARGER_RELEASE_DELAY_US = 1500;

    // the same delays in ticks of the delay counter
    localparam int TD_OVCHG_TICKS  = TD_OVCHG_US * 1000 / TICK_NS;
    localparam int TR_OVCHG_TICKS  = TR_OVCHG_US * 1000 / TICK_NS;
    localparam int TD_OVDIS_TICKS  = TD_OVDIS_US * 1000 / TICK_NS;
    localparam int TR_OVDIS_TICKS  = TR_OVDIS_US * 1000 / TICK_NS;
    localparam int TD_OCUR_TICKS   = TD_OCUR_US * 1000 / TICK_NS;
    localparam int TR_OCUR_TICKS   = TR_OCUR_US * 1000 / TICK_NS;
    localparam int TD_SHORT_TICKS  = TD_SHORT_US * 1000 / TICK_NS;
    localparam int TD_EXCESS_TICKS =
        EXCESS_CHARGER_DETECT_DELAY_US * 1000 / TICK_NS;
    localparam int TR_EXCESS_TICKS =
        EXCESS_CHARGER_RELEASE_DELAY_US * 1000 / TICK_NS;

    // comparator results, all synchronous to clk
    typedef struct packed {
        logic [1:0] ovchg_det;
        logic [1:0] ovchg_rel;
        logic [1:0] ovdis_det;
        logic [1:0] ovdis_rel;
        logic       load_ocur;
        logic       load_short;
        logic       load_present;
        logic       excess_chg;
        logic       stby_release;
    } bgf_comp_type;

    // gate and pull controls driven by the guard
    typedef struct packed {
        logic chg_gate;
        logic dis_gate;
        logic pullup_en;
        logic pulldown_en;
        logic standby;
        logic small_hyst;
    } bgf_drive_type;

    localparam bgf_drive_type DRIVE_RESET = 6'h30;

    // delay limit, cut down in shortening mode but never below one tick
    function automatic logic [CNT_W-1:0] scale_delay(
        input logic [CNT_W-1:0] lim,
        input logic             shorten
    );
        logic [CNT_W-1:0] cut;
        cut = lim >> SHORT_SHIFT;
        if (!shorten) begin
            return lim;
        end
        return (cut == '0) ? CNT_W'(1) : cut;
    endfunction

endpackage

// File: test/bgf_env_model.sv
// behavioural cells, charger, load and switches around the guard
`timescale 1ns/10ps
module bgf_env_model import bgf_pkg::*; (
    input  wire logic [12:0]   cell0_mv,
    input  wire logic [12:0]   cell1_mv,
    input  wire logic          charger,
    input  wire logic          excess,
    input  wire logic          load,
    input  wire logic [1:0]    cur,
    input  wire bgf_drive_type drive,
    output wire bgf_comp_type  comp
);
    // cell monitor levels in millivolts: 4250, 4050, 2800, 2820
    localparam logic [12:0] OVCHG_DET_MV = 13'h109a;
    localparam logic [12:0] OVCHG_REL_MV = 13'hfd2;
    localparam logic [12:0] OVDIS_DET_MV = 13'haf0;
    localparam logic [12:0] OVDIS_REL_MV = 13'hb04;

    wire logic node_up;

    // per-cell comparators, bit i is cell i
    assign comp.ovchg_det = {cell1_mv >= OVCHG_DET_MV,
                             cell0_mv >= OVCHG_DET_MV};
    assign comp.ovchg_rel = {cell1_mv <= OVCHG_REL_MV,
                             cell0_mv <= OVCHG_REL_MV};
    assign comp.ovdis_det = {cell1_mv <= OVDIS_DET_MV,
                             cell0_mv <= OVDIS_DET_MV};
    assign comp.ovdis_rel = {cell1_mv >= OVDIS_REL_MV,
                             cell0_mv >= OVDIS_REL_MV};

    // an open discharge switch lets a connected load lift the node fully,
    // so the fault keeps showing until the load is taken away
    assign node_up = load && (cur != 2'h0 || !drive.dis_gate);
    assign comp.load_ocur = !charger && (node_up || drive.pullup_en);
    assign comp.load_short = !charger && load &&
                             (cur == 2'h2 || !drive.dis_gate);
    assign comp.load_present = load;
    // charging through the body diode drags the node below the excess level
    assign comp.excess_chg = charger && (excess || !drive.dis_gate);
    assign comp.stby_release = charger;
endmodule

// File: test/tb.sv
// self-checking bench for the battery guard with its surroundings
`timescale 1ns/10ps
module tb import bgf_pkg::*;;
    // shortened delays in ticks; over-current kept above the short delay
    localparam int DO = 16, RO = 8, DD = 12, RD = 6;
    localparam int DOC = 400, ROC = 5, DE = 8, RE = 8, T = TICK_CYCLES;
    localparam int B_CHG = 5, B_DIS = 4, B_PU = 3, B_STBY = 1, B_HYST = 0;
    // cell levels in millivolts: 3500, 4300, 4100, 2500
    localparam logic [12:0] NOM = 13'hdac, OV_HI = 13'h10cc;
    localparam logic [12:0] OV_MID = 13'h1004, UNDER = 13'h9c4;

    logic          clk, rst, test_shorten, charger, excess, load;
    logic [1:0]    cur;
    logic [12:0]   cell0, cell1;
    bgf_comp_type  comp;
    bgf_drive_type drive;
    int            failures, cmp_count;

    bgf_guard #(.DET_OVCHG_TICKS(DO), .REL_OVCHG_TICKS(RO),
        .DET_OVDIS_TICKS(DD), .REL_OVDIS_TICKS(RD),
        .DET_OCUR_TICKS(DOC), .REL_OCUR_TICKS(ROC),
        .DET_EXCESS_TICKS(DE), .REL_EXCESS_TICKS(RE)) DUT (
        .clk(clk), .rst(rst), .comp(comp),
        .test_shorten(test_shorten), .drive(drive));
    bgf_env_model env (.cell0_mv(cell0), .cell1_mv(cell1),
        .charger(charger), .excess(excess), .load(load), .cur(cur),
        .drive(drive), .comp(comp));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            $display("MISMATCH at %0t: seen %0h expected %0h", $time,
                     seen, exp);
            failures++;
        end
    endtask

    // earliest and latest cycle counts for a delay of l ticks
    function automatic int lo(input int l);
        return (l - 1) * T;
    endfunction
    function automatic int hi(input int l);
        return l * T + 30;
    endfunction

    // count cycles until a drive bit takes v; too early or never is a miss
    task automatic measure(input int b, input logic v, input int mn,
                           input int mx);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (drive[b] !== v && n <= mx);
        if (n > mx) begin
            check(drive[b], v);
            finish_test();
        end
        check(n >= mn, 1'b1);
    endtask

    // a drive bit must keep v for n cycles
    task automatic hold(input int b, input logic v, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(negedge clk);
            if (drive[b] !== v) bad = 1'b1;
        end
        check(bad, 1'b0);
    endtask

    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(drive, DRIVE_RESET);
    endtask

    task automatic t_overcharge();
        @(posedge clk);
        cell0 <= OV_HI;
        measure(B_CHG, 1'b0, lo(DO), hi(DO));
        check(drive.small_hyst, 1'b0);
        // shortened mode keeps the suppressed over-current test brief
        @(posedge clk);
        load <= 1'b1;
        cur <= 2'h1;
        test_shorten <= 1'b1;
        measure(B_HYST, 1'b1, 0, 4);
        hold(B_DIS, 1'b1, 10 * T);
        @(posedge clk);
        test_shorten <= 1'b0;
        cell0 <= OV_MID;
        hold(B_CHG, 1'b0, (RO + 3) * T);
        @(posedge clk);
        cell0 <= NOM;
        measure(B_CHG, 1'b1, lo(RO), hi(RO));
        @(posedge clk);
        load <= 1'b0;
        cur <= 2'h0;
    endtask

    task automatic t_excess();
        @(posedge clk);
        charger <= 1'b1;
        excess <= 1'b1;
        hold(B_CHG, 1'b1, (DE - 2) * T);
        @(posedge clk);
        excess <= 1'b0;
        hold(B_CHG, 1'b1, 2 * T);
        @(posedge clk);
        excess <= 1'b1;
        measure(B_CHG, 1'b0, lo(DE), hi(DE));
        @(posedge clk);
        excess <= 1'b0;
        measure(B_CHG, 1'b1, lo(RE), hi(RE));
        @(posedge clk);
        cell0 <= OV_HI;
        measure(B_CHG, 1'b0, lo(DO), hi(DO));
        @(posedge clk);
        cell0 <= NOM;
        excess <= 1'b1;
        hold(B_CHG, 1'b0, (RO + DE + 3) * T);
        @(posedge clk);
        excess <= 1'b0;
        measure(B_CHG, 1'b1, lo(RE), hi(RE));
        @(posedge clk);
        charger <= 1'b0;
    endtask

    task automatic t_overdischarge();
        @(posedge clk);
        cell1 <= UNDER;
        measure(B_DIS, 1'b0, lo(DD), hi(DD));
        check(drive.standby, 1'b1);
        check(drive.pullup_en, 1'b1);
        hold(B_STBY, 1'b1, 4 * T);
        @(posedge clk);
        charger <= 1'b1;
        excess <= 1'b1;
        measure(B_STBY, 1'b0, 0, 3);
        check(drive.pullup_en, 1'b0);
        hold(B_DIS, 1'b0, (RD + 2) * T);
        check(drive.chg_gate, 1'b1);
        @(posedge clk);
        cell1 <= NOM;
        measure(B_DIS, 1'b1, lo(RD), hi(RD));
        measure(B_CHG, 1'b0, lo(DE), hi(DE));
        @(posedge clk);
        charger <= 1'b0;
        excess <= 1'b0;
        measure(B_CHG, 1'b1, lo(RE), hi(RE));
    endtask

    task automatic t_load_faults();
        @(posedge clk);
        load <= 1'b1;
        cur <= 2'h1;
        measure(B_DIS, 1'b0, lo(DOC), hi(DOC));
        check(drive.pulldown_en, 1'b1);
        check(drive.standby, 1'b0);
        @(posedge clk);
        load <= 1'b0;
        cur <= 2'h0;
        measure(B_DIS, 1'b1, lo(ROC), hi(ROC));
        check(drive.pulldown_en, 1'b0);
        @(posedge clk);
        test_shorten <= 1'b1;
        load <= 1'b1;
        cur <= 2'h1;
        measure(B_DIS, 1'b0, lo(DOC >> 6), hi(DOC >> 6));
        @(posedge clk);
        test_shorten <= 1'b0;
        load <= 1'b0;
        cur <= 2'h0;
        measure(B_DIS, 1'b1, 0, hi(ROC));
        @(posedge clk);
        load <= 1'b1;
        cur <= 2'h2;
        measure(B_DIS, 1'b0, lo(TD_SHORT_TICKS), hi(TD_SHORT_TICKS));
        check(drive.pulldown_en, 1'b1);
        check(drive.standby, 1'b0);
        @(posedge clk);
        load <= 1'b0;
        cur <= 2'h0;
        measure(B_DIS, 1'b1, lo(ROC), hi(ROC));
    endtask

    // main sequence; ends with a reset out of standby
    initial begin
        failures = 0;
        cmp_count = 0;
        rst = 1'b1;
        test_shorten = 1'b0;
        charger = 1'b0;
        excess = 1'b0;
        load = 1'b0;
        cur = 2'h0;
        cell0 = NOM;
        cell1 = NOM;
        t_reset();
        t_overcharge();
        t_excess();
        t_overdischarge();
        t_load_faults();
        @(posedge clk);
        cell1 <= UNDER;
        measure(B_DIS, 1'b0, lo(DD), hi(DD));
        t_reset();
        finish_test();
    end
endmodule
